//--- verification/sbst_jtag_model.sv
// test controller model driving the test pins
// assumes it is entered at a falling edge of i_clk, 8 clocks per tck
module sbst_jtag_model (
	// clock and serial output of the port
	input  logic i_clk,
	input  logic i_tdo,
	input  logic i_tdo_oe,
	// test pins
	output logic o_tck,
	output logic o_tms,
	output logic o_tdi
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		o_tck = 1'h0;
		o_tms = 1'h1;
		o_tdi = 1'h1;
	end
	// 160 ns period; tck rests low between frames
	task automatic step(input logic ms, input logic di, output logic dq);
		o_tms = ms;
		o_tdi = di;
		repeat (4) @(negedge i_clk);
		o_tck = 1'h1;
		repeat (3) @(negedge i_clk);
		dq = i_tdo_oe ? i_tdo : 1'hZ;
		@(negedge i_clk);
		o_tck = 1'h0;
	endtask
	// from idle through capture and shift, back to idle
	task automatic scan(input logic ir, input int n, input logic [68:0] din,
		output logic [68:0] dout);
		logic t;
		dout = '0;
		step(1'h1, 1'h1, t);
		if (ir)
			step(1'h1, 1'h1, t);
		step(1'h0, 1'h1, t);
		step(1'h0, 1'h1, t);
		for (int i = 0; i < n; i++) begin
			step(i == n - 1, din[i], t);
			dout[i] = t;
		end
		step(1'h1, 1'h1, t);
		step(1'h0, 1'h1, t);
	endtask
	task automatic tap_reset();
		logic t;
		repeat (5) step(1'h1, 1'h1, t);
		step(1'h0, 1'h1, t);
	endtask
endmodule

//--- verification/sbst_tap_assertions.sv
// concurrent checks on the ports of sbst_tap
// assumes tck is far slower than i_clk
module sbst_tap_assertions (
	input logic        i_clk,
	input logic        i_rst_b,
	input logic        i_ce,
	input logic        i_tck,
	input logic        i_tms,
	input logic        o_tdo,
	input logic        o_tdo_oe,
	input logic        o_sram_hiz,
	input logic        o_snap_valid,
	input logic        i_snap_ready,
	input logic [68:0] o_snap_data,
	input logic        o_snap_room
);
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_rst_b);
	logic       tck_q;
	logic [2:0] ones_q;
	// counts tck rises with tms high; a frozen port sees none
	always_ff @(posedge i_clk) begin
		tck_q <= i_tck;
		if (!i_rst_b || !i_ce)
			ones_q <= 3'h0;
		else if (i_tck && !tck_q)
			ones_q <= !i_tms ? 3'h0 : ones_q + {2'h0, ones_q != 3'h7};
	end
	a_reset_outs: assert property (disable iff (1'b0)
		!i_rst_b |=> !o_tdo_oe && !o_sram_hiz && !o_snap_valid && o_snap_room)
		else $error("outputs not at reset values");
	a_tdo_on_fall: assert property ($changed(o_tdo) |-> !i_tck &&
		($past(i_tck, 2) || $past(i_tck, 3) || $past(i_tck, 4)))
		else $error("tdo moved away from a tck fall");
	a_oe_on_fall: assert property ($changed(o_tdo_oe) |-> !i_tck &&
		($past(i_tck, 2) || $past(i_tck, 3) || $past(i_tck, 4)))
		else $error("tdo enable moved away from a tck fall");
	a_quiet_idle: assert property (!i_tck [*8] |=> $stable(o_tdo) &&
		$stable(o_tdo_oe) && $stable(o_sram_hiz))
		else $error("port moved without tck");
	a_five_ones: assert property ($rose(ones_q == 3'h5) |->
		##[1:8] (!o_sram_hiz && !o_tdo_oe))
		else $error("five tms highs did not reset the port");
	a_snap_hold: assert property (o_snap_valid && !i_snap_ready |=>
		o_snap_valid && $stable(o_snap_data))
		else $error("snapshot lost while stalled");
	a_full_nonempty: assert property (!o_snap_room |-> o_snap_valid)
		else $error("full buffer shows no data");
	a_push_timing: assert property ($rose(o_snap_valid) |->
		$past(i_tck, 3) || $past(i_tck, 4) || $past(i_tck, 5))
		else $error("snapshot appeared without a capture");
endmodule
bind sbst_tap sbst_tap_assertions i_chk (.*);

//--- verification/tb_top.sv
// self-checking bench for the sram boundary-scan port
// assumes the jtag model drives the pins; the bench drives the rest
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	typedef struct {
		logic [2:0]  code;
		int          len;
		logic        hiz;
		logic [68:0] exp;
	} sbst_row_t;
	localparam logic [68:0] ID_W = {37'h0, 3'h5, 17'h0A5A5, 11'h2C3, 1'h1};
	localparam logic [68:0] RING = 69'h1D3C5A9F0E6B217A48;
	logic        clk, rst_b, ce, tck, tms, tdi, tdo, tdo_oe, hiz;
	logic        snap_valid, snap_ready, snap_room;
	logic [68:0] ring, snap_data, dout;
	int          n_mismatch, num_checks;
	sbst_row_t   rows [8];
	// id field values are arbitrary
	sbst_tap #(.ID_REV(3'h5), .ID_DEV(17'h0A5A5), .ID_VEN(11'h2C3)) i_dut (
		.i_clk(clk), .i_rst_b(rst_b), .i_ce(ce), .i_tck(tck), .i_tms(tms),
		.i_tdi(tdi), .o_tdo(tdo), .o_tdo_oe(tdo_oe), .i_ring(ring),
		.o_sram_hiz(hiz), .o_snap_valid(snap_valid),
		.i_snap_ready(snap_ready), .o_snap_data(snap_data),
		.o_snap_room(snap_room));
	sbst_jtag_model i_jtag (.i_clk(clk), .i_tdo(tdo), .i_tdo_oe(tdo_oe),
		.o_tck(tck), .o_tms(tms), .o_tdi(tdi));
	////////////////////////////////////////////////////////////////
	task automatic check(input logic [69:0] seen, input logic [69:0] exp);
		num_checks++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic load(input logic [2:0] code);
		i_jtag.scan(1'h1, 3, {66'h0, code}, dout);
		check(dout, 70'h1);
	endtask
	// one ready cycle, then let the flags settle
	task automatic pop();
		snap_ready = 1'h1;
		@(negedge clk);
		snap_ready = 1'h0;
		repeat (2) @(negedge clk);
	endtask
	task automatic final_report();
		$display("checks %0d mismatches %0d", num_checks, n_mismatch);
		if (n_mismatch == 0 && num_checks > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	////////////////////////////////////////////////////////////////
	initial begin
		clk = 1'h0;
		forever #10 clk = ~clk;
	end
	initial begin
		#400us;
		n_mismatch++;
		final_report();
	end
	initial begin
		rst_b = 1'h0;
		ce = 1'h1;
		ring = RING;
		snap_ready = 1'h0;
		// only defined codes are loaded; bypass rows read back the
		// cleared bit, then the first tdi bits
		rows = '{'{3'h0, 69, 1'h1, RING}, '{3'h1, 32, 1'h0, ID_W},
			'{3'h2, 69, 1'h1, RING}, '{3'h7, 1, 1'h0, 69'h0},
			'{3'h4, 69, 1'h0, RING}, '{3'h1, 1, 1'h0, 69'h1},
			'{3'h7, 3, 1'h0, 69'h6}, '{3'h7, 2, 1'h0, 69'h2}};
		repeat (8) @(negedge clk);
		rst_b = 1'h1;
		// the port wakes in its reset state; walk it to idle first
		i_jtag.tap_reset();
		foreach (rows[i]) begin
			load(rows[i].code);
			check(hiz, rows[i].hiz);
			i_jtag.scan(1'h0, rows[i].len, '1, dout);
			check(dout, rows[i].exp);
			check(tdo_oe, 1'h0);
			if (rows[i].len == 69) begin
				check(snap_data, RING);
				pop();
			end
			check(snap_valid, 1'h0);
		end
		// reset in mid-run with the memory outputs floated
		load(3'h0);
		rst_b = 1'h0;
		repeat (8) @(negedge clk);
		check({hiz, tdo_oe, snap_valid, snap_room}, 70'h1);
		rst_b = 1'h1;
		i_jtag.tap_reset();
		i_jtag.scan(1'h0, 32, '1, dout);
		check(dout, ID_W);
		// edges while frozen are lost, then a real tms reset
		load(3'h2);
		ce = 1'h0;
		i_jtag.tap_reset();
		ce = 1'h1;
		check(hiz, 1'h1);
		i_jtag.tap_reset();
		check(hiz, 1'h0);
		i_jtag.scan(1'h0, 32, '1, dout);
		check(dout, ID_W);
		// fill with the drain stalled, one capture too many, then drain
		load(3'h4);
		for (int k = 0; k < 17; k++) begin
			ring = RING ^ 69'(k);
			i_jtag.scan(1'h0, 1, '1, dout);
		end
		check(snap_room, 1'h0);
		for (int k = 0; k < 16; k++) begin
			check({snap_valid, snap_data}, {1'h1, RING ^ 69'(k)});
			pop();
		end
		check({snap_valid, snap_room}, 70'h1);
		final_report();
	end
endmodule

//--- verilog/sbst_consts.vh
// constants for the boundary-scan test port of the pipelined sram
// assumes it is included by bare name from the design files only
`ifndef SBST_CONSTS_VH
`define SBST_CONSTS_VH

// scan register widths
`define SBST_IR_W        3
`define SBST_ID_W        32
`define SBST_BSR_W       69

// instruction codes
`define SBST_INS_HIZCAP  3'h0
`define SBST_INS_IDREAD  3'h1
`define SBST_INS_SAMPZ   3'h2
`define SBST_INS_SAMPLE  3'h4
`define SBST_INS_BYPASS  3'h7

// capture-ir pattern, low two bits are the fixed 01
`define SBST_IR_CAPTURE  3'h1

// identification word field positions
`define SBST_ID_REV_MSB  31
`define SBST_ID_REV_LSB  29
`define SBST_ID_DEV_MSB  28
`define SBST_ID_DEV_LSB  12
`define SBST_ID_VEN_MSB  11
`define SBST_ID_VEN_LSB  1
`define SBST_ID_PRESENT  0

// reset values
`define SBST_RST_PIN_HI  1'h1
`define SBST_RST_TCK     1'h0
`define SBST_RST_BYPASS  1'h0

// snapshot buffer
`define SBST_SNAP_DEPTH  16
`define SBST_SNAP_AW     4

`endif

//--- verilog/sbst_tap.v
// boundary-scan test access port of the sram, with a snapshot buffer
// assumes tck, tms, tdi and the pin ring are asynchronous to i_clk,
// and that i_clk runs well above four times the test clock rate
//
// How it works
// (R1) port wakes in reset state, quiet; a stopped test clock changes nothing
// (R2) inputs taken on test clock rise, outputs launched on its fall
// (R3) mode-select and data-in read high when left unconnected
// (R4) serial data enters at msb and leaves from lsb
// (R5) data output enabled only in the two shift states
// (R6) five mode-select highs on rising edges reach reset state
// (R7) reset starts the data output in high impedance
// (R8) one scan register in the path, chosen by active instruction
// (R9) three-bit instruction register, loaded with id-read on reset
// (R10) capture-instruction loads low two instruction bits with 01
// (R11) one-bit bypass in path under bypass, cleared on capture
// (R12) boundary register is 69 bits for both data widths
// (R13) boundary register captures the ring, then shifts
// (R14) id-read captures a hardwired 32-bit code and shifts it
// (R15) controller must not load the three reserved codes
// (R16) port only observes pins, never drives the memory core
// (R17) shifted instruction takes effect at update-instruction only
// (R18) all-zero code acts as sample and floats memory outputs
// (R19) high-z sample puts boundary register in path, floats outputs
// (R20) sample snapshots the pins on capture-data, memory unaffected
// (R21) update-data under sample has no effect, like a pause
// (R22) controller keeps test clock at or below 10 MHz
// (R23) code 001 is id-read and 111 is bypass
// (R24) code 010 is high-z sample, 100 sample; 011, 101, 110 reserved
// (R25) id word: revision 31:29, device 28:12, vendor 11:1, bit 0 one
// (R26) sixteen-state controller steps on each test clock rise

`include "sbst_consts.vh"

////////////////////////////////////////////////////////////////////////
// snapshot fifo

module sbst_fifo #(
	parameter WIDTH = 69,
	parameter DEPTH = 16,
	parameter AW    = 4
) (
	// clock and reset
	input  wire             i_clk,
	input  wire             i_rst_b,
	input  wire             i_ce,
	// filling side
	input  wire             i_in_valid,
	output wire             o_in_ready,
	input  wire [WIDTH-1:0] i_in_data,
	// draining side
	output wire             o_out_valid,
	input  wire             i_out_ready,
	output wire [WIDTH-1:0] o_out_data
);
	localparam [AW:0] FULL_CNT = DEPTH[AW:0];

	reg [WIDTH-1:0] mem_q [0:DEPTH-1];
	reg [AW-1:0]    wr_q;
	reg [AW-1:0]    rd_q;
	reg [AW:0]      cnt_q;
	reg [AW:0]      cnt_d;
	reg [WIDTH-1:0] head_q;
	reg             room_q;
	reg             nempty_q;
	wire            push;
	wire            pop;

	assign push        = i_in_valid & room_q;
	assign pop         = nempty_q & i_out_ready;
	assign o_in_ready  = room_q;
	assign o_out_valid = nempty_q;
	assign o_out_data  = head_q;

	always @* begin
		cnt_d = cnt_q;
		if (push & ~pop)
			cnt_d = cnt_q + 1'b1;
		else if (pop & ~push)
			cnt_d = cnt_q - 1'b1;
	end

	always @(posedge i_clk) begin
		if (!i_rst_b) begin
			wr_q     <= {AW{1'b0}};
			rd_q     <= {AW{1'b0}};
			cnt_q    <= {(AW+1){1'b0}};
			room_q   <= 1'b1;
			nempty_q <= 1'b0;
		end else if (i_ce) begin
			if (push)
				wr_q <= wr_q + 1'b1;
			if (pop)
				rd_q <= rd_q + 1'b1;
			cnt_q    <= cnt_d;
			room_q   <= (cnt_d != FULL_CNT);
			nempty_q <= (cnt_d != {(AW+1){1'b0}});
		end
	end

	// memory has no reset; an unwritten slot only reaches the head copy as the buffer empties
	always @(posedge i_clk) begin
		if (i_ce && push)
			mem_q[wr_q] <= i_in_data;
	end

	// head copy keeps the output on a flop; next slot is read ahead
	always @(posedge i_clk) begin
		if (!i_rst_b) begin
			head_q <= {WIDTH{1'b0}};
		end else if (i_ce) begin
			if (push && (!nempty_q ||
			    (pop && cnt_q == {{AW{1'b0}}, 1'b1})))
				head_q <= i_in_data;
			else if (pop)
				head_q <= mem_q[rd_q + 1'b1];
		end
	end
endmodule

////////////////////////////////////////////////////////////////////////
// test access port

module sbst_tap #(
	// identification fields, values are arbitrary
	parameter [2:0]  ID_REV = 3'h0,
	parameter [16:0] ID_DEV = 17'h00000,
	parameter [10:0] ID_VEN = 11'h000
) (
	// clock, reset, enable
	input  wire                   i_clk,
	input  wire                   i_rst_b,
	input  wire                   i_ce,
	// test pins
	input  wire                   i_tck,
	input  wire                   i_tms,
	input  wire                   i_tdi,
	output reg                    o_tdo,
	output reg                    o_tdo_oe,
	// memory pin ring and output float control
	input  wire [`SBST_BSR_W-1:0] i_ring,
	output reg                    o_sram_hiz,
	// snapshot stream
	output wire                   o_snap_valid,
	input  wire                   i_snap_ready,
	output wire [`SBST_BSR_W-1:0] o_snap_data,
	output wire                   o_snap_room
);
	localparam [3:0] ST_TLR    = 4'h0;
	localparam [3:0] ST_RTI    = 4'h1;
	localparam [3:0] ST_SEL_DR = 4'h2;
	localparam [3:0] ST_CAP_DR = 4'h3;
	localparam [3:0] ST_SH_DR  = 4'h4;
	localparam [3:0] ST_EX1_DR = 4'h5;
	localparam [3:0] ST_PAU_DR = 4'h6;
	localparam [3:0] ST_EX2_DR = 4'h7;
	localparam [3:0] ST_UPD_DR = 4'h8;
	localparam [3:0] ST_SEL_IR = 4'h9;
	localparam [3:0] ST_CAP_IR = 4'hA;
	localparam [3:0] ST_SH_IR  = 4'hB;
	localparam [3:0] ST_EX1_IR = 4'hC;
	localparam [3:0] ST_PAU_IR = 4'hD;
	localparam [3:0] ST_EX2_IR = 4'hE;
	localparam [3:0] ST_UPD_IR = 4'hF;

	localparam [1:0] SEL_BYP = 2'h0;
	localparam [1:0] SEL_ID  = 2'h1;
	localparam [1:0] SEL_BSR = 2'h2;

	// hardwired identification word, presence bit forced to one
	localparam [`SBST_ID_W-1:0] ID_WORD =
		{ID_REV, ID_DEV, ID_VEN, 1'b1};  // see (R25)

	reg                   tck_s1_q;
	reg                   tck_s2_q;
	reg                   tck_s3_q;
	reg                   tms_s1_q;
	reg                   tms_s2_q;
	reg                   tdi_s1_q;
	reg                   tdi_s2_q;
	reg [`SBST_BSR_W-1:0] ring_s1_q;
	reg [`SBST_BSR_W-1:0] ring_s2_q;
	reg [3:0]             st_q;
	reg [3:0]             st_d;
	reg [`SBST_IR_W-1:0]  ir_q;
	reg [`SBST_IR_W-1:0]  ir_sh_q;
	reg                   byp_q;
	reg [`SBST_ID_W-1:0]  id_q;
	reg [`SBST_BSR_W-1:0] bsr_q;
	reg [1:0]             sel;
	reg                   dr_lsb;
	reg                   snap_push_q;
	wire                  tck_rise;
	wire                  tck_fall;

	////////////////////////////////////////////////////////////////////
	// input synchronisers

	// a test clock tied low never makes an edge, so the port stays put
	assign tck_rise = tck_s2_q & ~tck_s3_q;  // see (R1)
	assign tck_fall = ~tck_s2_q & tck_s3_q;  // see (R2)

	always @(posedge i_clk) begin
		if (!i_rst_b) begin
			tck_s1_q <= `SBST_RST_TCK;
			tck_s2_q <= `SBST_RST_TCK;
			tck_s3_q <= `SBST_RST_TCK;
			// pulled-up pins start high, as an open pin would read
			tms_s1_q <= `SBST_RST_PIN_HI;  // see (R3)
			tms_s2_q <= `SBST_RST_PIN_HI;  // see (R3)
			tdi_s1_q <= `SBST_RST_PIN_HI;  // see (R3)
			tdi_s2_q <= `SBST_RST_PIN_HI;  // see (R3)
		end else if (i_ce) begin
			tck_s1_q <= i_tck;
			tck_s2_q <= tck_s1_q;
			tck_s3_q <= tck_s2_q;
			tms_s1_q <= i_tms;
			tms_s2_q <= tms_s1_q;
			tdi_s1_q <= i_tdi;
			tdi_s2_q <= tdi_s1_q;
		end
	end

	// ring bits are synchronised one by one, so a bit caught mid
	// transition settles to some value but never spreads metastability
	genvar g;
	generate
		for (g = 0; g < `SBST_BSR_W; g = g + 1) begin : g_ring
			always @(posedge i_clk) begin
				if (!i_rst_b) begin
					ring_s1_q[g] <= 1'b0;
					ring_s2_q[g] <= 1'b0;
				end else if (i_ce) begin
					ring_s1_q[g] <= i_ring[g];
					ring_s2_q[g] <= ring_s1_q[g];
				end
			end
		end
	endgenerate

	////////////////////////////////////////////////////////////////////
	// controller

	always @* begin
		st_d = st_q;
		case (st_q)
			// from any state, five highs walk into reset
			ST_TLR:    st_d = tms_s2_q ? ST_TLR    : ST_RTI;  // see (R6)
			ST_RTI:    st_d = tms_s2_q ? ST_SEL_DR : ST_RTI;
			ST_SEL_DR: st_d = tms_s2_q ? ST_SEL_IR : ST_CAP_DR;
			ST_CAP_DR: st_d = tms_s2_q ? ST_EX1_DR : ST_SH_DR;
			ST_SH_DR:  st_d = tms_s2_q ? ST_EX1_DR : ST_SH_DR;
			ST_EX1_DR: st_d = tms_s2_q ? ST_UPD_DR : ST_PAU_DR;
			ST_PAU_DR: st_d = tms_s2_q ? ST_EX2_DR : ST_PAU_DR;
			ST_EX2_DR: st_d = tms_s2_q ? ST_UPD_DR : ST_SH_DR;
			ST_UPD_DR: st_d = tms_s2_q ? ST_SEL_DR : ST_RTI;
			ST_SEL_IR: st_d = tms_s2_q ? ST_TLR    : ST_CAP_IR;  // see (R6)
			ST_CAP_IR: st_d = tms_s2_q ? ST_EX1_IR : ST_SH_IR;
			ST_SH_IR:  st_d = tms_s2_q ? ST_EX1_IR : ST_SH_IR;
			ST_EX1_IR: st_d = tms_s2_q ? ST_UPD_IR : ST_PAU_IR;
			ST_PAU_IR: st_d = tms_s2_q ? ST_EX2_IR : ST_PAU_IR;
			ST_EX2_IR: st_d = tms_s2_q ? ST_UPD_IR : ST_SH_IR;
			ST_UPD_IR: st_d = tms_s2_q ? ST_SEL_DR : ST_RTI;
			default:   st_d = ST_TLR;
		endcase
	end

	always @(posedge i_clk) begin
		if (!i_rst_b)
			st_q <= ST_TLR;  // see (R1)
		else if (i_ce && tck_rise)
			st_q <= st_d;  // see (R26)
	end

	////////////////////////////////////////////////////////////////////
	// instruction decode

	// reserved codes fall back to bypass, the harmless choice
	always @* begin
		case (ir_q)
			`SBST_INS_HIZCAP: sel = SEL_BSR;  // see (R18)
			`SBST_INS_IDREAD: sel = SEL_ID;   // see (R23)
			`SBST_INS_SAMPZ:  sel = SEL_BSR;  // see (R19)
			`SBST_INS_SAMPLE: sel = SEL_BSR;  // see (R24)
			`SBST_INS_BYPASS: sel = SEL_BYP;  // see (R23)
			default:          sel = SEL_BYP;
		endcase
	end

	// only one data register feeds the output at a time
	always @* begin
		case (sel)
			SEL_ID:  dr_lsb = id_q[0];   // see (R8)
			SEL_BSR: dr_lsb = bsr_q[0];  // see (R8)
			default: dr_lsb = byp_q;
		endcase
	end

	////////////////////////////////////////////////////////////////////
	// instruction register

	always @(posedge i_clk) begin
		if (!i_rst_b) begin
			ir_q    <= `SBST_INS_IDREAD;  // see (R9)
			ir_sh_q <= `SBST_IR_CAPTURE;
		end else if (i_ce && tck_rise) begin
			case (st_q)
				ST_CAP_IR: ir_sh_q <= `SBST_IR_CAPTURE;  // see (R10)
				ST_SH_IR:  ir_sh_q <= {tdi_s2_q, ir_sh_q[2:1]};  // see (R4)
				ST_UPD_IR: ir_q <= ir_sh_q;  // see (R17)
				default:   ir_q <= ir_q;
			endcase
			// id-read holds from the very rise that enters reset state
			if (st_d == ST_TLR)
				ir_q <= `SBST_INS_IDREAD;  // see (R9)
		end
	end

	////////////////////////////////////////////////////////////////////
	// data registers

	// update-data loads nothing: no preload stage exists
	always @(posedge i_clk) begin
		if (!i_rst_b) begin
			byp_q       <= `SBST_RST_BYPASS;
			id_q        <= ID_WORD;
			bsr_q       <= {`SBST_BSR_W{1'b0}};
			snap_push_q <= 1'b0;
		end else if (i_ce) begin
			snap_push_q <= 1'b0;
			if (tck_rise && st_q == ST_CAP_DR) begin
				byp_q <= 1'b0;  // see (R11)
				if (sel == SEL_ID)
					id_q <= ID_WORD;  // see (R14)
				if (sel == SEL_BSR) begin
					bsr_q       <= ring_s2_q;  // see (R13)
					snap_push_q <= 1'b1;  // see (R20)
				end
			end else if (tck_rise && st_q == ST_SH_DR) begin  // see (R21)
				case (sel)
					SEL_ID:  id_q <= {tdi_s2_q, id_q[31:1]};  // see (R4)
					SEL_BSR: bsr_q <= {tdi_s2_q, bsr_q[68:1]};  // see (R12)
					default: byp_q <= tdi_s2_q;  // see (R11)
				endcase
			end
		end
	end

	////////////////////////////////////////////////////////////////////
	// output launch and memory output float

	always @(posedge i_clk) begin
		if (!i_rst_b) begin
			o_tdo      <= 1'b0;
			o_tdo_oe   <= 1'b0;  // see (R7)
			o_sram_hiz <= 1'b0;
		end else if (i_ce) begin
			if (tck_fall) begin
				o_tdo    <= (st_q == ST_SH_IR) ? ir_sh_q[0] : dr_lsb;  // see (R2)
				o_tdo_oe <= (st_q == ST_SH_IR) || (st_q == ST_SH_DR);  // see (R5)
			end
			// float control only; the port never drives core values
			o_sram_hiz <= (ir_q == `SBST_INS_HIZCAP) ||  // see (R18)
			              (ir_q == `SBST_INS_SAMPZ);     // see (R16)
		end
	end

	////////////////////////////////////////////////////////////////////
	// snapshot stream

	// a full buffer drops the copy; the scan capture itself still runs
	sbst_fifo #(
		.WIDTH (`SBST_BSR_W),
		.DEPTH (`SBST_SNAP_DEPTH),
		.AW    (`SBST_SNAP_AW)
	) u_snap (
		.i_clk       (i_clk),
		.i_rst_b     (i_rst_b),
		.i_ce        (i_ce),
		.i_in_valid  (snap_push_q),
		.o_in_ready  (o_snap_room),
		.i_in_data   (bsr_q),
		.o_out_valid (o_snap_valid),
		.i_out_ready (i_snap_ready),
		.o_out_data  (o_snap_data)
	);
endmodule
